//--- bench/btd_core_bench.sv
/*
  Self-checking bench for the decode core with its memory model.
  Assumes one instruction per run call and fixed bank 3.
*/
`timescale 1ns/1ns
`default_nettype none
module btd_core_bench;
  // ==========================================================
  // Signals
  logic sys_clk, reset, extEnable, carryIn, fileWrite;
  logic negFlag, zeroFlag, idleCycle, seenWr;
  logic [3:0] bankSel;
  logic [11:0] indexBase, fileAddrOut, seenAddr;
  logic [15:0] instr, nextInstr;
  logic [7:0] fileRdata, fileWdata, accum;
  logic [20:0] pc;
  int fails, n_checks, cycles;
  btd_core dut_u (.sys_clk, .reset, .instr, .nextInstr, .pc, .fileRdata,
    .fileAddrOut, .fileWdata, .fileWrite, .extEnable, .bankSel,
    .indexBase, .carryIn, .accum, .negFlag, .zeroFlag, .idleCycle);
  btd_mem_model mem_u (.sys_clk, .pc, .instr, .nextInstr, .fileRdata,
    .fileAddrOut, .fileWdata, .fileWrite);
  // ==========================================================
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  task chk(input string nm, input logic [20:0] e, s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One instruction: pc step, then idle count
  task run(input logic [15:0] op, nx, input logic [11:0] base,
    input logic ext, cy, input logic [20:0] dl, input int ni);
    logic [20:0] p0;
    int n;
    p0 = pc;
    mem_u.prog[p0[8:1]] = op;
    mem_u.prog[p0[8:1] + 8'h01] = nx;
    extEnable <= ext;
    indexBase <= base;
    carryIn <= cy;
    @(posedge sys_clk);
    #1;
    seenWr = fileWrite;
    seenAddr = fileAddrOut;
    chk("pc", p0 + dl, pc);
    n = 0;
    while (idleCycle === 1'b1 && n < 4) begin
      n++;
      @(posedge sys_clk);
      #1;
    end
    chk("idle", 21'(ni), 21'(n));
  endtask
  // AND with file; address looked at only when written
  task andOp(input logic [15:0] op, input logic [11:0] base,
    input logic ext, input logic [11:0] ad, input logic wr);
    run(op, 16'h0000, base, ext, 1'b0, 21'h2, 0);
    chk("write", 21'(wr), 21'(seenWr));
    chk("wdata", 21'h0, 21'(fileWdata));
    if (wr) chk("addr", 21'(ad), 21'(seenAddr));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    extEnable = 1'b0;
    carryIn = 1'b0;
    bankSel = 4'h3;
    indexBase = 12'h000;
    for (int i = 0; i < 256; i++) begin
      mem_u.prog[i] = 16'h0000;
      mem_u.dataMem[i] = 8'h00;
    end
    mem_u.dataMem[8'h45] = 8'hC2;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("pc reset", 21'h0, pc);
    andOp(16'h1733, 12'h000, 1'b0, 12'h333, 1'b1);
    andOp(16'h1670, 12'h000, 1'b0, 12'hF70, 1'b1);
    andOp(16'h1610, 12'h200, 1'b0, 12'h010, 1'b1);
    andOp(16'h1610, 12'h200, 1'b1, 12'h210, 1'b1);
    andOp(16'h165F, 12'h200, 1'b1, 12'h25F, 1'b1);
    andOp(16'h1660, 12'h200, 1'b1, 12'hF60, 1'b1);
    andOp(16'h1545, 12'h000, 1'b0, 12'h000, 1'b0);
    chk("accum", 21'h0, 21'(accum));
    chk("zero", 21'h1, 21'(zeroFlag));
    chk("neg", 21'h0, 21'(negFlag));
    $display("test and done");
    run(16'hE205, 16'h0, 12'h0, 1'b0, 1'b1, 21'd12, 1);
    run(16'hE205, 16'h0, 12'h0, 1'b0, 1'b0, 21'd2, 0);
    run(16'hE27F, 16'h0, 12'h0, 1'b0, 1'b1, 21'd256, 1);
    run(16'hE280, 16'h0, 12'h0, 1'b0, 1'b1, -21'd254, 1);
    chk("zero kept", 21'h1, 21'(zeroFlag));
    $display("test branch done");
    run(16'hB045, 16'h0000, 12'h0, 1'b0, 1'b0, 21'd4, 1);
    run(16'hB045, 16'hF000, 12'h0, 1'b0, 1'b0, 21'd6, 2);
    run(16'hB245, 16'hF000, 12'h0, 1'b0, 1'b0, 21'd2, 0);
    run(16'hAE45, 16'h0000, 12'h0, 1'b0, 1'b0, 21'd4, 1);
    run(16'hAE45, 16'hF123, 12'h0, 1'b0, 1'b0, 21'd6, 2);
    run(16'hA045, 16'h0000, 12'h0, 1'b0, 1'b0, 21'd2, 0);
    chk("flags kept", 21'h1, 21'(zeroFlag));
    $display("test skip done");
    summarize();
  end
endmodule // btd_core_bench
`default_nettype wire

//--- bench/btd_mem_model.sv
/*
  Program memory and data file model facing the decode core.
  Assumes the core reads both combinationally and writes on a pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module btd_mem_model (
  // Clock
  input wire logic sys_clk,
  // Program side
  input wire logic [20:0] pc,
  output logic [15:0] instr,
  output logic [15:0] nextInstr,
  // File side
  output logic [7:0] fileRdata,
  input wire logic [11:0] fileAddrOut,
  input wire logic [7:0] fileWdata,
  input wire logic fileWrite
);
  // ==========================================================
  // Storage; higher address bits alias, bench keeps f apart
  logic [15:0] prog [256];
  logic [7:0] dataMem [256];
  // Fetch word and follower
  assign instr = prog[pc[8:1]];
  assign nextInstr = prog[pc[8:1] + 8'h01];
  // Bank bits ignored to keep the model small
  assign fileRdata = dataMem[instr[7:0]];
  // Write back on the pulse
  always @(posedge sys_clk) begin
    if (fileWrite) begin
      dataMem[fileAddrOut[7:0]] <= fileWdata;
    end
  end
endmodule // btd_mem_model
`default_nettype wire

//--- rtl/btd_addr_form.sv
/*
  Forms the 12-bit data address from f, a, the bank register and the
  indexed offset mode. Assumes the index base comes from the core.
*/
`timescale 1ns/1ns
`default_nettype none
module btd_addr_form
  import btd_pkg::*;
(
  // File operand
  btd_file_if.former fif,
  // Mode and bases
  input wire logic extEnable,
  input wire logic [3:0] bankSel,
  input wire logic [11:0] indexBase
);
  // ==========================================================
  // Address selection
  always_comb begin
    if (fif.access) begin
      fif.fullAddr = {bankSel, fif.fileAddr};
    end else if (extEnable && fif.fileAddr <= IDX_LIMIT) begin
      fif.fullAddr = indexBase + {4'h0, fif.fileAddr};
    end else if (fif.fileAddr < ACC_SPLIT) begin
      fif.fullAddr = {4'h0, fif.fileAddr};
    end else begin
      fif.fullAddr = {SFR_BANK, fif.fileAddr}; // Upper access half
    end
  end
endmodule // btd_addr_form
`default_nettype wire

//--- rtl/btd_core.sv
/*
  Executes AND-with-file, carry branch and bit-test skips.
  Assumes program memory and file data are valid combinationally.
*/
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module btd_core
  import btd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Program memory
  input wire logic [15:0] instr,
  input wire logic [15:0] nextInstr,
  output logic [20:0] pc,
  // Data file
  input wire logic [7:0] fileRdata,
  output logic [11:0] fileAddrOut,
  output logic [7:0] fileWdata,
  output logic fileWrite,
  // Mode and state
  input wire logic extEnable,
  input wire logic [3:0] bankSel,
  input wire logic [11:0] indexBase,
  input wire logic carryIn,
  output logic [7:0] accum,
  output logic negFlag,
  output logic zeroFlag,
  output logic idleCycle
);
  btd_file_if fif();
  logic isAnd, isBrc, isSkc, isSks, skipNow, branchNow, idle, bitVal;
  logic [7:0] andRes;
  logic [20:0] next_pc, offs;
  logic [7:0] next_accum, next_wdata;
  logic next_neg, next_zero, next_write;
  logic [11:0] next_addr;
  // ==========================================================
  // Submodules
  btd_addr_form uForm (
    .fif(fif.former), .extEnable(extEnable), .bankSel(bankSel),
    .indexBase(indexBase));
  btd_skip_ctl uSkip (
    .sys_clk(sys_clk), .reset(reset), .skipNow(skipNow),
    .twoWord(nextInstr[15:12] == OP_TWO), .branchNow(branchNow),
    .idle(idle));
  // Decode
  assign isAnd = !idle && instr[15:10] == OP_AND;
  assign isBrc = !idle && instr[15:8] == OP_BRC;
  assign isSkc = !idle && instr[15:12] == OP_SKC;
  assign isSks = !idle && instr[15:12] == OP_SKS;
  assign fif.fileAddr = instr[7:0];
  assign fif.access = instr[8];
  assign bitVal = fileRdata[instr[11:9]];
  assign skipNow = (isSkc && !bitVal) || (isSks && bitVal);
  assign branchNow = isBrc && carryIn;
  assign andRes = accum & fileRdata;
  assign offs = {{12{instr[7]}}, instr[7:0], 1'b0};
  // ==========================================================
  // Next values
  always_comb begin
    next_pc = pc + PC_STEP;
    next_accum = accum;
    next_neg = negFlag;
    next_zero = zeroFlag;
    next_write = 1'b0;
    next_wdata = fileWdata;
    next_addr = fileAddrOut;
    if (branchNow) begin
      next_pc = pc + PC_STEP + offs;
    end else if (idle) begin
      next_pc = pc;
    end else if (skipNow) begin
      next_pc = pc + PC_STEP + PC_STEP;
      if (nextInstr[15:12] == OP_TWO) begin
        next_pc = pc + PC_STEP + PC_STEP + PC_STEP;
      end
    end
    if (isAnd) begin
      next_neg = andRes[7];
      next_zero = (andRes == RESET_BYTE);
      if (instr[9]) begin
        next_write = 1'b1;
        next_wdata = andRes;
        next_addr = fif.fullAddr;
      end else begin
        next_accum = andRes;
      end
    end
  end
  // Register all
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pc <= RESET_PC;
      accum <= RESET_BYTE;
      negFlag <= 1'b0;
      zeroFlag <= 1'b0;
      fileWrite <= 1'b0;
      fileWdata <= RESET_BYTE;
      fileAddrOut <= 12'h000;
      idleCycle <= 1'b0;
    end else begin
      pc <= next_pc;
      accum <= next_accum;
      negFlag <= next_neg;
      zeroFlag <= next_zero;
      fileWrite <= next_write;
      fileWdata <= next_wdata;
      fileAddrOut <= next_addr;
      idleCycle <= skipNow || branchNow || (idle && uSkip.next_state != BTD_RUN);
    end
  end
  // ==========================================================
  // Checks
  a_branch_target: assert property (
    @(posedge sys_clk) disable iff (reset)
    branchNow |=> pc == $past(pc) + PC_STEP + $past(offs))
    else $error("branch target wrong");
  a_flags_kept: assert property (
    @(posedge sys_clk) disable iff (reset)
    (isBrc || isSkc || isSks) |=> $stable(negFlag) && $stable(zeroFlag))
    else $error("flags changed");
  a_skip_idle: assert property (
    @(posedge sys_clk) disable iff (reset)
    skipNow |=> idle)
    else $error("no idle after skip");
  a_and_dest: assert property (
    @(posedge sys_clk) disable iff (reset)
    (isAnd && !instr[9]) |=> accum == $past(andRes))
    else $error("and result lost");
  // Two-word follower must cost two idle cycles, not one
  a_skip_two: assert property (
    @(posedge sys_clk) disable iff (reset)
    (skipNow && nextInstr[15:12] == OP_TWO) |=> idle ##1 idle)
    else $error("two-word skip too short");
  // Idle cycles hold the program counter
  a_idle_hold: assert property (
    @(posedge sys_clk) disable iff (reset)
    idle |=> $stable(pc))
    else $error("pc moved while idle");
  // Branch not taken costs one cycle only
  a_branch_fall: assert property (
    @(posedge sys_clk) disable iff (reset)
    (isBrc && !carryIn) |=> !idle)
    else $error("idle after untaken branch");
endmodule // btd_core
`default_nettype wire

//--- rtl/btd_file_if.sv
/*
  Interface carrying the data register file access between the core and
  its address former. Assumes one-cycle combinational read data.
*/
`timescale 1ns/1ns
`default_nettype none
interface btd_file_if;
  logic [7:0] fileAddr;   // Operand f
  logic access;           // Operand a
  logic [11:0] fullAddr;  // Formed address
  modport core (output fileAddr, output access, input fullAddr);
  modport former (input fileAddr, input access, output fullAddr);
endinterface // btd_file_if
`default_nettype wire

//--- rtl/btd_pkg.sv
/*
  Constants, opcode fields and enumerations for the bit-test, branch and
  logic decode block. Assumes a 16-bit instruction word and 8-bit data.
*/
package btd_pkg;
  // ==========================================================
  // Opcode fields
  localparam logic [5:0] OP_AND = 6'h05;   // 0001_01da
  localparam logic [7:0] OP_BRC = 8'hE2;   // 1110_0010
  localparam logic [3:0] OP_SKC = 4'hB;    // 1011_bbba
  localparam logic [3:0] OP_SKS = 4'hA;    // 1010_bbba
  localparam logic [3:0] OP_TWO = 4'hF;    // Two-word opcode prefix
  localparam logic [7:0] IDX_LIMIT = 8'h5F; // Highest indexed offset
  localparam logic [7:0] ACC_SPLIT = 8'h60; // Access bank low half end
  localparam logic [3:0] SFR_BANK = 4'hF;  // Upper access half bank
  localparam logic [20:0] PC_STEP = 21'h00_0002; // Word step in bytes
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [20:0] RESET_PC = 21'h00_0000;
  // Execution state
  typedef enum logic [1:0] {BTD_RUN, BTD_IDLE1, BTD_IDLE2} btd_state_t;
endpackage

//--- rtl/btd_skip_ctl.sv
/*
  Counts the idle cycles after a skip or a taken branch.
  Assumes a two-word follower is flagged by the core.
*/
`timescale 1ns/1ns
`default_nettype none
module btd_skip_ctl
  import btd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Requests
  input wire logic skipNow,
  input wire logic twoWord,
  input wire logic branchNow,
  // Status
  output logic idle
);
  btd_state_t state; // Current
  btd_state_t next_state; // Next
  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state = BTD_RUN;
    case (state)
      BTD_RUN: begin
        if (skipNow && twoWord) begin
          next_state = BTD_IDLE2;
        end else if (skipNow || branchNow) begin
          next_state = BTD_IDLE1;
        end
      end
      BTD_IDLE2: next_state = BTD_IDLE1;
      default: next_state = BTD_RUN;
    endcase
  end
  // Register
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= BTD_RUN;
    end else begin
      state <= next_state;
    end
  end
  assign idle = (state != BTD_RUN);
endmodule // btd_skip_ctl
`default_nettype wire
